// [inc/afe_pkg.sv]
// package: register map, field layout and timing constants for the analog front end control
package afe_pkg;
    // register indices; the byte address on the bus is 4 * index
    localparam logic [7:0] IDX_INT_FLAGS = 8'h06;
    localparam logic [7:0] IDX_INT_ENABLES = 8'h07;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h10;
    localparam logic [7:0] IDX_RESULT_LOW = 8'h11;
    localparam logic [7:0] IDX_CONV_CTRL = 8'h13;
    localparam logic [7:0] IDX_CLOCK_SEL = 8'h14;
    localparam logic [7:0] IDX_MUX_A = 8'h18;
    localparam logic [7:0] IDX_MUX_B = 8'h19;
    localparam logic [7:0] IDX_REF_GAIN = 8'h1A;
    localparam logic [7:0] IDX_AMP_CTRL = 8'h1B;
    localparam logic [7:0] IDX_BITSTREAM = 8'h1C;
    localparam int ADDR_W = 8;

    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions
    localparam int FLAG_CONV_BIT = 2;
    localparam int GLOBAL_IRQ_BIT = 7;
    localparam int COMB_EN_BIT = 3;
    localparam int CLKSEL_BIT = 1;
    localparam int LPF_EN_BIT = 2;
    localparam int REFEN_BIT = 7;
    localparam int MOD_EN_BIT = 1;
    localparam int SHORT_BIT = 0;
    localparam int AMP2_EN_BIT = 7;
    localparam int AMP1_EN_BIT = 3;

    // sample clock dividers, result width and full-scale figure
    localparam logic [5:0] SAMPLE_DIV_FAST = 6'd25;
    localparam logic [5:0] SAMPLE_DIV_SLOW = 6'd50;
    localparam int RESULT_W = 16;
    localparam logic [15:0] FULL_SCALE = 16'd15625;

    // one-hot analog switch selection: bit n closes the switch to source n
    typedef enum logic [3:0] {
        AFE_SRC_IN0, AFE_SRC_IN1, AFE_SRC_IN2, AFE_SRC_IN3,
        AFE_SRC_IN4, AFE_SRC_IN5, AFE_SRC_IN6, AFE_SRC_IN7,
        AFE_SRC_GND, AFE_SRC_OWN_OUT, AFE_SRC_TAP2, AFE_SRC_TAP1,
        AFE_SRC_TEMP, AFE_SRC_NODE_A, AFE_SRC_NODE_B, AFE_SRC_NODE_C
    } afe_src_t;

    // switch enables presented to the analog macro
    typedef struct packed {
        logic [15:0] amp1_pos;
        logic [15:0] amp1_neg;
        logic [15:0] amp2_pos;
        logic [15:0] amp2_neg;
        logic [15:0] ref_pos;
        logic [15:0] ref_neg;
        logic [15:0] filter_in;
        logic [15:0] conv_pos;
        logic [15:0] conv_neg;
    } afe_switch_t;

    typedef struct packed {
        logic amp1_en;
        logic amp2_en;
        logic ref_div_en;
        logic lpf_en;
        logic mod_en;
        logic input_short;
        logic [1:0] gain_sel;
    } afe_ctrl_t;
endpackage

// [hw/afe_ctrl.sv]
// analog front end and sigma-delta converter control with apb register file
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module afe_ctrl
    import afe_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic modulator_bit,
    output logic sample_strobe,
    output afe_switch_t switch_sel,
    output afe_ctrl_t analog_ctrl,
    output logic converter_irq
);

    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    logic [7:0] int_flags_reg;
    logic [7:0] int_enables_reg;
    logic [3:0] conv_ctrl_reg;
    logic clock_sel_reg;
    logic [7:0] mux_a_reg;
    logic [7:0] mux_b_reg;
    logic [7:0] ref_gain_reg;
    logic [7:0] amp_ctrl_reg;
    logic [RESULT_W-1:0] result_reg;
    logic new_result;

    logic [ADDR_W-1:0] reg_index;
    logic access;
    logic wr_en;
    logic mapped;
    assign reg_index = paddr[ADDR_W+1:2];
    assign access = psel & penable;
    assign wr_en = access & pwrite;
    // single-cycle access phase; no wait states
    assign pready = 1'b1;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] idx);
        is_mapped = (idx == IDX_INT_FLAGS) || (idx == IDX_INT_ENABLES) ||
                    (idx == IDX_RESULT_HIGH) || (idx == IDX_RESULT_LOW) ||
                    (idx == IDX_CONV_CTRL) || (idx == IDX_CLOCK_SEL) ||
                    (idx == IDX_MUX_A) || (idx == IDX_MUX_B) ||
                    (idx == IDX_REF_GAIN) || (idx == IDX_AMP_CTRL) ||
                    (idx == IDX_BITSTREAM);
    endfunction

    assign mapped = is_mapped(reg_index) && (paddr[1:0] == 2'b00) &&
                    (paddr[31:ADDR_W+2] == '0);
    // result registers are read-only; writing them is an error too
    assign pslverr = access & (!mapped | (pwrite & ((reg_index == IDX_RESULT_HIGH) |
                     (reg_index == IDX_RESULT_LOW))));

    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            conv_ctrl_reg <= 4'h0;
            clock_sel_reg <= 1'b0;
            mux_a_reg <= REG_RESET;
            mux_b_reg <= REG_RESET;
            ref_gain_reg <= REG_RESET;
            amp_ctrl_reg <= REG_RESET;
            int_enables_reg <= REG_RESET;
        end else if (wr_en && mapped) begin
            unique case (reg_index)
                IDX_CONV_CTRL: conv_ctrl_reg <= pwdata[3:0];
                IDX_CLOCK_SEL: clock_sel_reg <= pwdata[CLKSEL_BIT];
                IDX_MUX_A: mux_a_reg <= pwdata[7:0];
                IDX_MUX_B: mux_b_reg <= pwdata[7:0];
                IDX_REF_GAIN: ref_gain_reg <= pwdata[7:0];
                IDX_AMP_CTRL: amp_ctrl_reg <= pwdata[7:0];
                IDX_INT_ENABLES: int_enables_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // flag set by hardware wins over a software clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            int_flags_reg <= REG_RESET;
        end else begin
            if (wr_en && mapped && reg_index == IDX_INT_FLAGS) begin
                int_flags_reg <= pwdata[7:0];
            end
            if (new_result) begin
                int_flags_reg[FLAG_CONV_BIT] <= 1'b1;
            end
        end
    end

    assign converter_irq = int_flags_reg[FLAG_CONV_BIT] &
                           int_enables_reg[FLAG_CONV_BIT] & int_enables_reg[GLOBAL_IRQ_BIT];

    always_comb begin
        prdata = 32'h0000_0000;
        if (access && !pwrite && mapped) begin
            unique case (reg_index)
                IDX_INT_FLAGS: prdata[7:0] = int_flags_reg;
                IDX_INT_ENABLES: prdata[7:0] = int_enables_reg;
                IDX_RESULT_HIGH: prdata[7:0] = result_reg[15:8];
                IDX_RESULT_LOW: prdata[7:0] = result_reg[7:0];
                IDX_CONV_CTRL: prdata[3:0] = conv_ctrl_reg;
                IDX_CLOCK_SEL: prdata[CLKSEL_BIT] = clock_sel_reg;
                IDX_MUX_A: prdata[7:0] = mux_a_reg;
                IDX_MUX_B: prdata[7:0] = mux_b_reg;
                IDX_REF_GAIN: prdata[7:0] = ref_gain_reg;
                IDX_AMP_CTRL: prdata[7:0] = amp_ctrl_reg;
                IDX_BITSTREAM: prdata[0] = modulator_bit;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // analog switch decode
    // ----------------------------------------------------------------
    function automatic logic [15:0] onehot(input afe_src_t src);
        onehot = 16'h0001 << src;
    endfunction

    always_comb begin
        switch_sel = '0;
        unique case (mux_b_reg[7:6])
            2'b00: switch_sel.amp2_neg = onehot(AFE_SRC_OWN_OUT);
            2'b01: switch_sel.amp2_neg = onehot(AFE_SRC_IN7);
            default: switch_sel.amp2_neg = 16'h0000;
        endcase
        unique case (mux_b_reg[5:4])
            2'b00: switch_sel.amp1_neg = onehot(AFE_SRC_OWN_OUT);
            2'b01: switch_sel.amp1_neg = onehot(AFE_SRC_IN4);
            2'b10: switch_sel.amp1_neg = onehot(AFE_SRC_IN5);
            2'b11: switch_sel.amp1_neg = onehot(AFE_SRC_IN3);
        endcase
        unique case (mux_b_reg[3:2])
            2'b00: switch_sel.ref_neg = onehot(AFE_SRC_GND);
            2'b01: switch_sel.ref_neg = onehot(AFE_SRC_IN1);
            2'b10: switch_sel.ref_neg = onehot(AFE_SRC_IN2);
            2'b11: switch_sel.ref_neg = onehot(AFE_SRC_TAP1);
        endcase
        unique case (mux_b_reg[1:0])
            2'b00: switch_sel.ref_pos = onehot(AFE_SRC_IN0);
            2'b01: switch_sel.ref_pos = onehot(AFE_SRC_IN3);
            2'b10: switch_sel.ref_pos = onehot(AFE_SRC_TAP2);
            2'b11: switch_sel.ref_pos = onehot(AFE_SRC_TAP1);
        endcase
        if (!amp_ctrl_reg[6]) begin
            switch_sel.amp2_pos = onehot(afe_src_t'({2'b01, amp_ctrl_reg[5:4]}));
        end
        switch_sel.amp1_pos = onehot(afe_src_t'({1'b0, amp_ctrl_reg[2:0]}));
        // node_a = amp1 output, node_b = amp1 noninverting node
        unique case (mux_a_reg[5:3])
            3'b000: switch_sel.filter_in = onehot(AFE_SRC_NODE_A);
            3'b001: switch_sel.filter_in = onehot(AFE_SRC_NODE_B);
            3'b010: switch_sel.filter_in = onehot(AFE_SRC_TAP2);
            3'b011: switch_sel.filter_in = onehot(AFE_SRC_TAP1);
            3'b100: switch_sel.filter_in = onehot(AFE_SRC_TEMP);
            3'b101: switch_sel.filter_in = onehot(AFE_SRC_IN5);
            3'b110: switch_sel.filter_in = onehot(AFE_SRC_IN4);
            3'b111: switch_sel.filter_in = onehot(AFE_SRC_GND);
        endcase
        // node_c = filtered node, node_a = unfiltered filter input node
        unique case (mux_a_reg[1:0])
            2'b00: switch_sel.conv_pos = onehot(AFE_SRC_NODE_C);
            2'b01: switch_sel.conv_pos = onehot(AFE_SRC_NODE_A);
            2'b10: switch_sel.conv_pos = onehot(AFE_SRC_IN2);
            2'b11: switch_sel.conv_pos = onehot(AFE_SRC_IN3);
        endcase
        unique case (mux_a_reg[7:6])
            2'b00: switch_sel.conv_neg = onehot(AFE_SRC_IN1);
            2'b01: switch_sel.conv_neg = onehot(AFE_SRC_IN2);
            2'b10: switch_sel.conv_neg = onehot(AFE_SRC_IN3);
            2'b11: switch_sel.conv_neg = onehot(AFE_SRC_TEMP);
        endcase
        // shorted inputs both follow the negative mux
        if (ref_gain_reg[SHORT_BIT]) begin
            switch_sel.conv_pos = switch_sel.conv_neg;
        end
    end

    // in filter_in TAP2/TAP1 stand for positive/negative reference nodes
    always_comb begin
        analog_ctrl.amp1_en = amp_ctrl_reg[AMP1_EN_BIT];
        analog_ctrl.amp2_en = amp_ctrl_reg[AMP2_EN_BIT];
        analog_ctrl.ref_div_en = ref_gain_reg[REFEN_BIT];
        analog_ctrl.lpf_en = mux_a_reg[LPF_EN_BIT];
        analog_ctrl.mod_en = ref_gain_reg[MOD_EN_BIT];
        analog_ctrl.input_short = ref_gain_reg[SHORT_BIT];
        analog_ctrl.gain_sel = ref_gain_reg[3:2];
    end

    // ----------------------------------------------------------------
    // sample clock and decimation
    // ----------------------------------------------------------------
    logic [5:0] div_cnt_reg;
    logic [5:0] div_limit;
    assign div_limit = clock_sel_reg ? SAMPLE_DIV_SLOW : SAMPLE_DIV_FAST;

    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            div_cnt_reg <= 6'd0;
        end else if (div_cnt_reg >= div_limit - 6'd1) begin
            div_cnt_reg <= 6'd0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'd1;
        end
    end
    assign sample_strobe = (div_cnt_reg == 6'd0) & ref_gain_reg[MOD_EN_BIT];

    function automatic logic [12:0] rate_samples(input logic [2:0] code);
        unique case (code)
            3'b000: rate_samples = 13'd125;
            3'b001: rate_samples = 13'd250;
            3'b010: rate_samples = 13'd500;
            3'b011: rate_samples = 13'd1000;
            3'b100: rate_samples = 13'd2000;
            3'b101: rate_samples = 13'd4000;
            default: rate_samples = 13'd8000;
        endcase
    endfunction

    // first-order count of ones; 2 x density - 1 scaled to full scale
    logic [12:0] samp_cnt_reg;
    logic [12:0] ones_cnt_reg;
    logic [12:0] n_samples;
    logic comb_en;
    logic [31:0] scaled;
    assign n_samples = rate_samples(conv_ctrl_reg[2:0]);
    assign comb_en = conv_ctrl_reg[COMB_EN_BIT];
    assign new_result = comb_en & sample_strobe & (samp_cnt_reg == n_samples - 13'd1);
    // bipolar: (2*ones - N) * full scale / N
    assign scaled = ((32'(ones_cnt_reg + 13'(modulator_bit)) << 1) - 32'(n_samples))
                    * 32'(FULL_SCALE);

    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            samp_cnt_reg <= 13'd0;
            ones_cnt_reg <= 13'd0;
        end else if (!comb_en) begin
            samp_cnt_reg <= 13'd0;
            ones_cnt_reg <= 13'd0;
        end else if (sample_strobe) begin
            if (new_result) begin
                samp_cnt_reg <= 13'd0;
                ones_cnt_reg <= 13'd0;
            end else begin
                samp_cnt_reg <= samp_cnt_reg + 13'd1;
                ones_cnt_reg <= ones_cnt_reg + 13'(modulator_bit);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            result_reg <= 16'h0000;
        end else if (!comb_en) begin
            result_reg <= 16'h0000;
        end else if (new_result) begin
            result_reg <= 16'($signed(scaled) / $signed({19'd0, n_samples}));
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_comb_zero;
        @(posedge core_clk) disable iff (!rst_n_reg)
        !comb_en |=> (result_reg == 16'h0000);
    endproperty
    a_comb_zero: assert property (p_comb_zero) else $error("result not zero");

    property p_flag_set;
        @(posedge core_clk) disable iff (!rst_n_reg)
        new_result |=> int_flags_reg[FLAG_CONV_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_write_takes;
        @(posedge core_clk) disable iff (!rst_n_reg)
        (wr_en && reg_index == IDX_MUX_B && mapped) |=> (mux_b_reg == $past(pwdata[7:0]));
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("write lost");

    property p_short;
        @(posedge core_clk) disable iff (!rst_n_reg)
        ref_gain_reg[SHORT_BIT] |-> (switch_sel.conv_pos == switch_sel.conv_neg);
    endproperty
    a_short: assert property (p_short) else $error("inputs not shorted");

    property p_amp2_open;
        @(posedge core_clk) disable iff (!rst_n_reg)
        mux_b_reg[7] |-> (switch_sel.amp2_neg == 16'h0000);
    endproperty
    a_amp2_open: assert property (p_amp2_open) else $error("switch closed");

    property p_amp2_pos_open;
        @(posedge core_clk) disable iff (!rst_n_reg)
        amp_ctrl_reg[6] |-> (switch_sel.amp2_pos == 16'h0000);
    endproperty
    a_amp2_pos_open: assert property (p_amp2_pos_open) else $error("switch closed");

    property p_div_fast;
        @(posedge core_clk) disable iff (!rst_n_reg)
        ($rose(sample_strobe) && !clock_sel_reg && $stable(clock_sel_reg))
        |-> ##25 (sample_strobe || !ref_gain_reg[MOD_EN_BIT] || clock_sel_reg);
    endproperty
    a_div_fast: assert property (p_div_fast) else $error("bad sample rate");

    property p_amp1_pos;
        @(posedge core_clk) disable iff (!rst_n_reg)
        switch_sel.amp1_pos[amp_ctrl_reg[2:0]];
    endproperty
    a_amp1_pos: assert property (p_amp1_pos) else $error("amp1 select wrong");

    // while the comb filter is on, a result may only change at the end of a full window of samples
    property p_result_hold;
        @(posedge core_clk) disable iff (!rst_n_reg)
        (comb_en && !new_result) |=> $stable(result_reg);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed early");

    property p_filter_onehot;
        @(posedge core_clk) disable iff (!rst_n_reg)
        $onehot(switch_sel.filter_in);
    endproperty
    a_filter_onehot: assert property (p_filter_onehot) else $error("filter input not one-hot");

endmodule

// [testbench/afe_mod_model.sv]
// far-side model: modulator bitstream source paced by the sample strobe
`timescale 1ns/100ps
module afe_mod_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sample_strobe,
    output logic modulator_bit
);
    // four ones in every five samples, so any window of 125*k samples holds exactly 4/5 ones
    logic [2:0] phase_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= 3'h0;
        end else if (sample_strobe) begin
            phase_reg <= (phase_reg == 3'h4) ? 3'h0 : phase_reg + 3'h1;
        end
    end
    assign modulator_bit = (phase_reg != 3'h4);
endmodule

// [testbench/afe_ctrl_tb_top.sv]
// self-checking bench for the analog front end control block
`timescale 1ns/100ps
module afe_ctrl_tb_top;
    import afe_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, modulator_bit, sample_strobe, converter_irq;
    afe_switch_t switch_sel;
    afe_ctrl_t analog_ctrl;
    int num_errors = 0, num_checks = 0, cyc = 0, t1, t2, seed_dummy;
    logic [7:0] ra, rb, rc, rd, v, idx;
    logic [31:0] rdat;
    logic err;
    // source index per code, -1 means no switch closed
    int t_a2n[4] = '{9, 7, -1, -1};
    int t_a1n[4] = '{9, 4, 5, 3};
    int t_rp[4] = '{0, 3, 10, 11};
    int t_rn[4] = '{8, 1, 2, 11};
    int t_fi[8] = '{13, 14, 10, 11, 12, 5, 4, 8};
    int t_cp[4] = '{15, 13, 2, 3};
    int t_cn[4] = '{1, 2, 3, 12};

    afe_ctrl i_afe_ctrl (.core_clk(core_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .modulator_bit(modulator_bit), .sample_strobe(sample_strobe),
        .switch_sel(switch_sel), .analog_ctrl(analog_ctrl), .converter_irq(converter_irq));
    afe_mod_model i_afe_mod_model (.core_clk(core_clk), .resetn(resetn),
        .sample_strobe(sample_strobe), .modulator_bit(modulator_bit));

    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // expectation and check helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] oh(input int n);
        return (n < 0) ? 16'h0000 : (16'h0001 << n);
    endfunction
    function automatic afe_switch_t exp_sw(input logic [7:0] a, b, c, d);
        afe_switch_t s;
        s.amp1_pos = oh(int'(d[2:0]));
        s.amp1_neg = oh(t_a1n[b[5:4]]);
        s.amp2_pos = d[6] ? 16'h0000 : oh(4 + int'(d[5:4]));
        s.amp2_neg = oh(t_a2n[b[7:6]]);
        s.ref_pos = oh(t_rp[b[1:0]]);
        s.ref_neg = oh(t_rn[b[3:2]]);
        s.filter_in = oh(t_fi[a[5:3]]);
        s.conv_neg = oh(t_cn[a[7:6]]);
        s.conv_pos = c[0] ? s.conv_neg : oh(t_cp[a[1:0]]);
        return s;
    endfunction
    function automatic afe_ctrl_t exp_ctl(input logic [7:0] a, c, d);
        return {d[3], d[7], c[7], a[2], c[1], c[0], c[3:2]};
    endfunction
    task automatic chk(input string nm, input logic [143:0] exp, input logic [143:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("apb_timeout", 0, 1);
            final_report();
        end else begin
            rdat = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rdc(input string nm, input logic [7:0] ix, input logic [7:0] exp,
                       input logic [7:0] mask, input logic exp_err);
        apb(1'b0, ix, 8'h00);
        chk({nm, "_err"}, exp_err, err);
        if (!exp_err) chk(nm, exp & mask, rdat[7:0] & mask);
    endtask
    task automatic wait_ev(input bit use_irq, output int t);
        int n;
        for (n = 0; n < 20000; n++) begin
            @(posedge core_clk);
            #1;
            if ((use_irq ? converter_irq : sample_strobe) === 1'b1) break;
        end
        if (n >= 20000) begin
            chk("event_timeout", 0, 1);
            final_report();
        end else begin
            t = cyc;
        end
    endtask
    task automatic check_outputs();
        @(posedge core_clk);
        #1;
        chk("switch_sel", exp_sw(ra, rb, rc, rd), switch_sel);
        chk("analog_ctrl", exp_ctl(ra, rc, rd), analog_ctrl);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed_dummy = $urandom(84);
        {ra, rb, rc, rd} = 32'h0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge core_clk);
        check_outputs();
        rdc("flags_rst", IDX_INT_FLAGS, 8'h00, 8'hFF, 1'b0);
        // field sweep: all ones, all zeros, then random bytes
        for (int i = 0; i < 64; i++) begin
            v = (i < 4) ? 8'hFF : (i < 8) ? 8'h00 : 8'($urandom);
            case (i % 4)
                0: begin idx = IDX_MUX_A; ra = v; end
                1: begin idx = IDX_MUX_B; rb = v; end
                2: begin idx = IDX_REF_GAIN; rc = v; end
                default: begin idx = IDX_AMP_CTRL; rd = v; end
            endcase
            apb(1'b1, idx, v);
            check_outputs();
            rdc("readback", idx, v, (i % 4 == 2) ? 8'h8F : 8'hFF, 1'b0);
        end
        rdc("unmapped", 8'h30, 8'h00, 8'h00, 1'b1);
        apb(1'b1, IDX_RESULT_HIGH, 8'h5A);
        chk("result_write_err", 1'b1, err);
        // modulator off: no sample strobes
        rc = 8'h00;
        apb(1'b1, IDX_REF_GAIN, rc);
        t1 = 0;
        repeat (120) begin
            @(posedge core_clk);
            #1;
            if (sample_strobe === 1'b1) t1++;
        end
        chk("strobe_when_off", 0, t1);
        // no strobes, so the model's bit is frozen while it is read back
        rdc("bitstream", IDX_BITSTREAM, {7'h00, modulator_bit}, 8'h01, 1'b0);
        // sample clock divider, both selections
        for (int s = 1; s >= 0; s--) begin
            apb(1'b1, IDX_CLOCK_SEL, s ? 8'h02 : 8'h00);
            rc = 8'h02;
            apb(1'b1, IDX_REF_GAIN, rc);
            wait_ev(1'b0, t1);
            wait_ev(1'b0, t1);
            wait_ev(1'b0, t2);
            chk("strobe_period", s ? 50 : 25, t2 - t1);
        end
        // bring-up order: gain and reference enable, reference selects, then rate
        rc = 8'h8E;
        rb = 8'h0E;
        apb(1'b1, IDX_INT_ENABLES, 8'h84);
        apb(1'b1, IDX_REF_GAIN, rc);
        apb(1'b1, IDX_MUX_B, rb);
        check_outputs();
        // output rate codes 000 and 001; density 4/5 gives 3/5 of full scale
        for (int r = 0; r < 2; r++) begin
            apb(1'b1, IDX_CONV_CTRL, 8'h08 | 8'(r));
            wait_ev(1'b1, t1);
            apb(1'b1, IDX_INT_FLAGS, 8'h00);
            wait_ev(1'b1, t1);
            rdc("flag_set", IDX_INT_FLAGS, 8'h04, 8'h04, 1'b0);
            apb(1'b1, IDX_INT_FLAGS, 8'h00);
            wait_ev(1'b1, t2);
            chk("result_interval", (125 << r) * 25, t2 - t1);
            rdc("result_high", IDX_RESULT_HIGH, 8'h24, 8'hFF, 1'b0);
            rdc("result_low", IDX_RESULT_LOW, 8'h9F, 8'hFF, 1'b0);
            apb(1'b1, IDX_INT_FLAGS, 8'h00);
        end
        // comb filter off must pull a nonzero result back to zero
        apb(1'b1, IDX_CONV_CTRL, 8'h00);
        rdc("result_off_h", IDX_RESULT_HIGH, 8'h00, 8'hFF, 1'b0);
        rdc("result_off_l", IDX_RESULT_LOW, 8'h00, 8'hFF, 1'b0);
        final_report();
    end
endmodule
